// [core/ccr_defs.svh]
// Offsets, field positions, power-on values and masks for the charger control register slice.
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH

`define CCR_DEV_ADDR 7'h3b
`define CCR_OFS_INSRC 8'h00
`define CCR_OFS_OPMODE 8'h01
`define CCR_OFS_LAST 8'h0f
`define CCR_UNMAPPED_RD 8'hff
`define CCR_UNIMPL_RD 8'h00

`define CCR_INSRC_POV 8'h17
`define CCR_OPMODE_POV 8'h1a

`define CCR_DISC_BIT 7
`define CCR_STAT_MSB 6
`define CCR_STAT_LSB 5
`define CCR_ILIM_MSB 4
`define CCR_ILIM_LSB 0
`define CCR_LLM_BIT 7
`define CCR_KICK_BIT 6
`define CCR_BOOST_BIT 5
`define CCR_CHG_BIT 4
`define CCR_SYSMIN_MSB 3
`define CCR_SYSMIN_LSB 1
`define CCR_MINBAT_BIT 0

`define CCR_INSRC_WD_MASK 8'h80
`define CCR_OPMODE_WD_MASK 8'h70
`define CCR_KICK_MASK 8'h40

`endif

// [core/ccr_pkg.sv]
// Types shared by the charger control register slice and its bus engine.
package ccr_pkg;

    // One cycle of traffic from the serial protocol engine, at byte level.
    typedef struct packed {
        logic       start;
        logic [6:0] dev_addr;
        logic       rw;
        logic       rx_valid;
        logic [7:0] rx_byte;
        logic       tx_req;
        logic       stop;
    } ccr_xfer_t;

    typedef enum logic [1:0] {
        CCR_STAT_CHARGE,
        CCR_STAT_PATTERN,
        CCR_STAT_FLOAT0,
        CCR_STAT_FLOAT1
    } ccr_stat_src_t;

endpackage

// [core/ccr_regs.sv]
// Charger control registers 0x00 and 0x01 behind a byte-level serial target port.
//
// Contract
// - Every register is eight bits, bit 0 least significant.
// - Target answers only at seven-bit address 0x3B; host uses it.
// - Register 0x00 is read/write, power-on value 00010111.
// - Register 0x01 is read/write, power-on value 00011010.
// - Register 0x00 bit 7 set isolates the input supply pin.
// - Register 0x00 bits 6:5 choose status pin source or float.
// - Register 0x00 bits 4:0 give input current limit code.
// - Detection result overwrites current limit; host writes only afterwards.
// - Register 0x01 bit 7 set disables light-load reduced frequency switching.
// - Writing 1 to register 0x01 bit 6 restarts the watchdog.
// - Watchdog kick bit returns to zero after the restart.
// - Register 0x01 bit 5 enables boost, overriding charge enable.
// - Charging only when bit 4 set and charge pin held low.
// - Register 0x01 bits 3:1 select the minimum system voltage.
// - Disconnect, kick, boost, charge bits also reset on watchdog expiry.
// - Reads beyond offset 0x0F return 0xFF.
// - Register pointer advances by one after each data byte.
`timescale 1ns/1ps
`include "ccr_defs.svh"

module ccr_regs (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire ccr_pkg::ccr_xfer_t xfer,
    input wire logic reg_reset_req,
    input wire logic wd_expired,
    input wire logic det_done,
    input wire logic [4:0] det_limit,
    input wire logic charge_enable_pin_n,
    output logic addr_ack,
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic input_isolated_state,
    output ccr_pkg::ccr_stat_src_t status_pin_source_sel,
    output logic [4:0] input_current_limit,
    output logic reduced_frequency_switching,
    output logic watchdog_kick,
    output logic boost_output_mode,
    output logic charge_active,
    output logic [2:0] min_system_voltage,
    output logic boost_min_battery_sel
);

    logic [7:0] insrc_reg;
    logic [7:0] insrc_next;
    logic [7:0] opmode_reg;
    logic [7:0] opmode_next;
    logic [7:0] ptr_reg;
    logic sel_reg;
    logic rd_reg;
    logic want_ptr_reg;
    logic kick_reg;

    wire addr_hit = xfer.start && (xfer.dev_addr == `CCR_DEV_ADDR);
    wire wr_ptr = sel_reg && !rd_reg && want_ptr_reg && xfer.rx_valid;
    wire wr_data = sel_reg && !rd_reg && !want_ptr_reg && xfer.rx_valid;
    wire rd_data = sel_reg && rd_reg && xfer.tx_req;
    wire wr0 = wr_data && (ptr_reg == `CCR_OFS_INSRC);
    wire wr1 = wr_data && (ptr_reg == `CCR_OFS_OPMODE);

    // Registers past 0x01 live elsewhere, so inside the map they read as zero here.
    wire [7:0] rd_val = (ptr_reg > `CCR_OFS_LAST) ? `CCR_UNMAPPED_RD :
                        (ptr_reg == `CCR_OFS_INSRC) ? insrc_reg :
                        (ptr_reg == `CCR_OFS_OPMODE) ? opmode_reg : `CCR_UNIMPL_RD;

    // A host write in the same cycle as a detection result loses the current limit field,
    // since the host is only expected to write after detection has settled.
    wire [7:0] insrc_wr = wr0 ? xfer.rx_byte : insrc_reg;
    wire [7:0] insrc_det = det_done ? {insrc_wr[7:5], det_limit} : insrc_wr;
    // A fresh kick written in the clearing cycle wins over the clear.
    wire [7:0] opmode_wr = wr1 ? xfer.rx_byte : (kick_reg ? (opmode_reg & ~`CCR_KICK_MASK) : opmode_reg);

    assign insrc_next = reg_reset_req ? `CCR_INSRC_POV :
                        wd_expired ? ((insrc_det & ~`CCR_INSRC_WD_MASK) | (`CCR_INSRC_POV & `CCR_INSRC_WD_MASK)) :
                        insrc_det;
    assign opmode_next = reg_reset_req ? `CCR_OPMODE_POV :
                         wd_expired ? ((opmode_wr & ~`CCR_OPMODE_WD_MASK) | (`CCR_OPMODE_POV & `CCR_OPMODE_WD_MASK)) :
                         opmode_wr;

    wire kick_next = opmode_reg[`CCR_KICK_BIT] && !kick_reg;
    wire boost_next = opmode_reg[`CCR_BOOST_BIT];
    wire chg_next = opmode_reg[`CCR_CHG_BIT] && !charge_enable_pin_n && !boost_next;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            insrc_reg <= `CCR_INSRC_POV;
            opmode_reg <= `CCR_OPMODE_POV;
        end else begin
            insrc_reg <= insrc_next;
            opmode_reg <= opmode_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            sel_reg <= 1'b0;
            rd_reg <= 1'b0;
            want_ptr_reg <= 1'b0;
            ptr_reg <= 8'h00;
        end else if (xfer.start) begin
            sel_reg <= addr_hit;
            rd_reg <= xfer.rw;
            want_ptr_reg <= !xfer.rw;
        end else if (xfer.stop) begin
            sel_reg <= 1'b0;
        end else if (wr_ptr) begin
            ptr_reg <= xfer.rx_byte;
            want_ptr_reg <= 1'b0;
        end else if (wr_data || rd_data) begin
            ptr_reg <= ptr_reg + 8'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            addr_ack <= 1'b0;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
        end else begin
            addr_ack <= addr_hit;
            tx_valid <= rd_data;
            if (rd_data) begin
                tx_data <= rd_val;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            input_isolated_state <= 1'b0;
            status_pin_source_sel <= ccr_pkg::CCR_STAT_CHARGE;
            input_current_limit <= 5'h17;
            reduced_frequency_switching <= 1'b1;
            watchdog_kick <= 1'b0;
            kick_reg <= 1'b0;
            boost_output_mode <= 1'b0;
            charge_active <= 1'b0;
            min_system_voltage <= 3'h5;
            boost_min_battery_sel <= 1'b0;
        end else begin
            input_isolated_state <= insrc_reg[`CCR_DISC_BIT];
            status_pin_source_sel <= ccr_pkg::ccr_stat_src_t'(insrc_reg[`CCR_STAT_MSB:`CCR_STAT_LSB]);
            input_current_limit <= insrc_reg[`CCR_ILIM_MSB:`CCR_ILIM_LSB];
            reduced_frequency_switching <= !opmode_reg[`CCR_LLM_BIT];
            kick_reg <= kick_next;
            watchdog_kick <= kick_next;
            boost_output_mode <= boost_next;
            charge_active <= chg_next;
            min_system_voltage <= opmode_reg[`CCR_SYSMIN_MSB:`CCR_SYSMIN_LSB];
            boost_min_battery_sel <= opmode_reg[`CCR_MINBAT_BIT];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // Target selection: only the own address opens a transaction, and a foreign one leaves every register alone.
    a_addr_match: assert property (
        xfer.start |=> addr_ack == ($past(xfer.dev_addr) == 7'h3b))
        else $error("Address acknowledge does not match target address.");

    a_addr_refuse: assert property (
        xfer.start && xfer.dev_addr != 7'h3b |=> !sel_reg && !addr_ack)
        else $error("Foreign address selected the target.");

    a_ack_source: assert property (
        addr_ack |-> $past(xfer.start))
        else $error("Address acknowledge without a start.");

    a_no_write_unsel: assert property (
        xfer.rx_valid && !sel_reg && !reg_reset_req && !wd_expired && !det_done && !kick_reg
        |=> insrc_reg == $past(insrc_reg) && opmode_reg == $past(opmode_reg))
        else $error("Register changed while the target was not selected.");

    // Register storage and power-on values.
    a_write_reg0: assert property (
        wr0 && !reg_reset_req && !wd_expired && !det_done |=> insrc_reg == $past(xfer.rx_byte))
        else $error("Write to offset 0x00 not stored.");

    a_write_reg1: assert property (
        wr1 && !reg_reset_req && !wd_expired |=> opmode_reg == $past(xfer.rx_byte))
        else $error("Write to offset 0x01 not stored.");

    a_reset_reg0: assert property (
        reg_reset_req |=> insrc_reg == 8'h17)
        else $error("Register reset did not restore offset 0x00.");

    a_reset_reg1: assert property (
        reg_reset_req |=> opmode_reg == 8'h1a)
        else $error("Register reset did not restore offset 0x01.");

    a_read_reg0: assert property (
        rd_data && ptr_reg == 8'h00 |=> tx_data == $past(insrc_reg))
        else $error("Read of offset 0x00 returned the wrong byte.");

    a_read_reg1: assert property (
        rd_data && ptr_reg == 8'h01 |=> tx_data == $past(opmode_reg))
        else $error("Read of offset 0x01 returned the wrong byte.");

    a_reg_hold: assert property (
        !wr0 && !reg_reset_req && !wd_expired && !det_done |=> insrc_reg == $past(insrc_reg))
        else $error("Offset 0x00 changed without a cause.");

    // Field outputs trail their register by exactly one cycle.
    a_isolate_follow: assert property (
        wr0 && !reg_reset_req && !wd_expired ##1 !reg_reset_req && !wd_expired
        |=> input_isolated_state == $past(xfer.rx_byte[7], 2))
        else $error("Input isolation output did not follow written bit.");

    a_isolate_map: assert property (
        input_isolated_state == $past(insrc_reg[7]))
        else $error("Input isolation output differs from its bit.");

    a_status_map: assert property (
        status_pin_source_sel == $past(insrc_reg[6:5]))
        else $error("Status pin source differs from its field.");

    a_limit_map: assert property (
        input_current_limit == $past(insrc_reg[4:0]))
        else $error("Input current limit output differs from its field.");

    a_det_overwrite: assert property (
        det_done && !reg_reset_req |=> insrc_reg[4:0] == $past(det_limit))
        else $error("Detection result did not overwrite current limit.");

    a_det_keeps_upper: assert property (
        det_done && !reg_reset_req && !wd_expired && !wr0 |=> insrc_reg[7:5] == $past(insrc_reg[7:5]))
        else $error("Detection result disturbed the upper fields.");

    a_llm_map: assert property (
        reduced_frequency_switching == !$past(opmode_reg[7]))
        else $error("Light-load switching output differs from its bit.");

    // The kick is a single pulse, and its bit falls back once the restart has gone out.
    a_kick_pulse: assert property (
        watchdog_kick |=> !watchdog_kick)
        else $error("Watchdog kick longer than one cycle.");

    a_kick_start: assert property (
        opmode_reg[6] && !kick_reg |=> watchdog_kick)
        else $error("Kick bit set but no restart pulse.");

    a_kick_clear: assert property (
        watchdog_kick && !wr1 && !reg_reset_req |=> !opmode_reg[6])
        else $error("Kick bit not cleared after restart.");

    a_boost_prio: assert property (
        boost_output_mode |-> !charge_active)
        else $error("Charging active while boost enabled.");

    a_boost_map: assert property (
        boost_output_mode == $past(opmode_reg[5]))
        else $error("Boost output differs from its bit.");

    a_charge_pin: assert property (
        opmode_reg[4] && !opmode_reg[5] && !charge_enable_pin_n |=> charge_active)
        else $error("Charge not enabled with bit set and pin low.");

    a_charge_block: assert property (
        charge_enable_pin_n || !opmode_reg[4] |=> !charge_active)
        else $error("Charge enabled without both bit and pin.");

    a_sysmin_map: assert property (
        min_system_voltage == $past(opmode_reg[3:1]))
        else $error("Minimum system voltage output differs from its field.");

    a_minbat_map: assert property (
        boost_min_battery_sel == $past(opmode_reg[0]))
        else $error("Boost battery threshold output differs from its bit.");

    // Expiry touches only the watchdog-reset fields.
    a_wd_defaults: assert property (
        wd_expired && !reg_reset_req
        |=> !insrc_reg[7] && opmode_reg[6:4] == 3'h1 && opmode_reg[3:0] == $past(opmode_wr[3:0]))
        else $error("Watchdog expiry reset the wrong fields.");

    a_wd_keeps_reg0: assert property (
        wd_expired && !reg_reset_req && !det_done && !wr0 |=> insrc_reg[6:0] == $past(insrc_reg[6:0]))
        else $error("Watchdog expiry disturbed fields of offset 0x00.");

    // Read path and pointer.
    a_unmapped_read: assert property (
        rd_data && ptr_reg > 8'h0f |=> tx_valid && tx_data == 8'hff)
        else $error("Read beyond map did not return 0xFF.");

    a_gap_read: assert property (
        rd_data && ptr_reg > 8'h01 && ptr_reg <= 8'h0f |=> tx_data == 8'h00)
        else $error("Read of an offset kept elsewhere did not return zero.");

    a_tx_follow: assert property (
        rd_data |=> tx_valid)
        else $error("Read request not answered in the next cycle.");

    a_ptr_advance: assert property (
        (wr_data || rd_data) && !xfer.start && !xfer.stop |=> ptr_reg == $past(ptr_reg) + 8'h01)
        else $error("Register pointer did not advance.");

    a_ptr_load: assert property (
        wr_ptr && !xfer.start && !xfer.stop |=> ptr_reg == $past(xfer.rx_byte))
        else $error("Pointer byte not loaded.");

    a_output_follow: assert property (
        wr1 && !reg_reset_req |=> ##1 min_system_voltage == $past(xfer.rx_byte[3:1], 2))
        else $error("Field output did not follow the write two cycles later.");

    c_multi_write: cover property (wr0 ##1 wr1);
    c_read_back: cover property (rd_data && ptr_reg == 8'h01);
    c_wd_expiry: cover property (wd_expired && opmode_reg[5]);
    c_kick: cover property (wr1 && xfer.rx_byte[6] ##[1:4] watchdog_kick);
    c_unmapped_read: cover property (rd_data && ptr_reg > 8'h0f);

endmodule // ccr_regs

// [testbench/ccr_host_model.sv]
// Byte-level model of the host that masters the serial bus.
`timescale 1ns/1ps
module ccr_host_model (
    input wire logic sys_clk,
    input wire logic addr_ack,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output ccr_pkg::ccr_xfer_t xfer
);
    initial xfer = '0;
    // Strobes other than stop stay up until the next task, so back-to-back bytes never lower and raise a strobe in one step.
    task automatic start(input logic [6:0] ad, input logic rw, output logic ack);
        xfer.rx_valid = 1'b0;
        xfer.tx_req = 1'b0;
        xfer.start = 1'b1;
        xfer.dev_addr = ad;
        xfer.rw = rw;
        @(posedge sys_clk);
        #1 ack = addr_ack;
    endtask
    task automatic put(input logic [7:0] b);
        xfer.start = 1'b0;
        xfer.rx_valid = 1'b1;
        xfer.rx_byte = b;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic get(output logic [7:0] b);
        xfer.start = 1'b0;
        xfer.tx_req = 1'b1;
        @(posedge sys_clk);
        #1 b = tx_valid ? tx_data : 8'hxx;
    endtask
    // A released data byte shows its inverse, so a stale byte is never taken for a fresh one.
    task automatic stop();
        xfer.start = 1'b0;
        xfer.rx_valid = 1'b0;
        xfer.tx_req = 1'b0;
        xfer.rx_byte = ~xfer.rx_byte;
        xfer.stop = 1'b1;
        @(posedge sys_clk);
        #1 xfer.stop = 1'b0;
    endtask
endmodule // ccr_host_model

// [testbench/test_ccr_regs.sv]
// Self-checking bench for the charger control register slice.
`timescale 1ns/1ps
module test_ccr_regs;
    logic sys_clk = 1'b0, rstn = 1'b0, reg_reset_req = 1'b0, wd_expired = 1'b0, det_done = 1'b0;
    logic charge_enable_pin_n = 1'b0, addr_ack, tx_valid, input_isolated_state, reduced_frequency_switching;
    logic watchdog_kick, boost_output_mode, charge_active, boost_min_battery_sel, ack;
    logic [4:0] det_limit = 5'h00, input_current_limit;
    logic [7:0] tx_data, a, b;
    logic [2:0] min_system_voltage;
    ccr_pkg::ccr_xfer_t xfer;
    ccr_pkg::ccr_stat_src_t status_pin_source_sel;
    int error_cnt = 0, total_checks = 0, kicks = 0;
    wire [7:0] o0 = {input_isolated_state, status_pin_source_sel, input_current_limit};
    wire [7:0] o1 = {~reduced_frequency_switching, watchdog_kick, boost_output_mode, charge_active,
        min_system_voltage, boost_min_battery_sel};
    ccr_regs dut_u (.sys_clk, .rstn, .xfer, .reg_reset_req, .wd_expired, .det_done, .det_limit,
        .charge_enable_pin_n, .addr_ack, .tx_data, .tx_valid, .input_isolated_state, .status_pin_source_sel,
        .input_current_limit, .reduced_frequency_switching, .watchdog_kick, .boost_output_mode,
        .charge_active, .min_system_voltage, .boost_min_battery_sel);
    ccr_host_model h_u (.sys_clk, .addr_ack, .tx_valid, .tx_data, .xfer);
    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) kicks += int'(watchdog_kick);
    function automatic logic [7:0] e1(input logic [7:0] d);
        return {d[7], 1'b0, d[5], d[4] & ~charge_enable_pin_n & ~d[5], d[3:0]};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic side(input logic [2:0] k);
        {reg_reset_req, wd_expired, det_done} = k;
        tick(1);
        {reg_reset_req, wd_expired, det_done} = 3'b000;
        tick(2);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1);
        h_u.start(7'h3b, 1'b0, ack);
        chk({7'h00, ack}, 8'h01);
        h_u.put(p);
        h_u.put(d0);
        h_u.put(d1);
        h_u.stop();
        tick(2);
    endtask
    task automatic rd(input logic [7:0] p, output logic [7:0] r0, output logic [7:0] r1);
        h_u.start(7'h3b, 1'b0, ack);
        h_u.put(p);
        h_u.start(7'h3b, 1'b1, ack);
        h_u.get(r0);
        h_u.get(r1);
        h_u.stop();
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #5000000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        tick(16);
        rstn = 1'b1;
        rd(8'h00, a, b);
        chk(a, 8'h17);
        chk(b, 8'h1a);
        chk(o1, e1(8'h1a));
        $display("test reset_values done");
        det_limit = 5'h1f;
        side(3'b001);
        chk(o0, 8'h1f);
        wr(8'h00, 8'ha3, 8'h8f);
        rd(8'h00, a, b);
        chk(a, 8'ha3);
        chk(b, 8'h8f);
        chk(o0, 8'ha3);
        chk(o1, e1(8'h8f));
        wr(8'h01, 8'h3b, 8'h00);
        chk(o1, e1(8'h3b));
        wr(8'h01, 8'h10, 8'h00);
        chk(o1, e1(8'h10));
        charge_enable_pin_n = 1'b1;
        tick(2);
        chk(o1, e1(8'h10));
        charge_enable_pin_n = 1'b0;
        $display("test field_outputs done");
        h_u.start(7'h3a, 1'b0, ack);
        chk({7'h00, ack}, 8'h00);
        h_u.put(8'h00);
        h_u.put(8'hff);
        h_u.stop();
        rd(8'h0f, a, b);
        chk(a, 8'h00);
        chk(b, 8'hff);
        chk(o0, 8'ha3);
        $display("test addressing done");
        kicks = 0;
        wr(8'h00, 8'h61, 8'h50);
        chk(8'(kicks), 8'h01);
        rd(8'h00, a, b);
        chk(a, 8'h61);
        chk(b, 8'h10);
        $display("test watchdog_kick done");
        wr(8'h00, 8'hd5, 8'ha7);
        side(3'b010);
        rd(8'h00, a, b);
        chk(a, 8'h55);
        chk(b, 8'h97);
        side(3'b100);
        chk(o0, 8'h17);
        chk(o1, e1(8'h1a));
        $display("test expiry_and_reset done");
        wrap_up();
    end
endmodule // test_ccr_regs
